// ==== inc/fcq_params.svh ====
/*
  Constants of the flash command decoder: command codes, command offsets,
  query table offsets and contents, write-buffer page layout, lock bits.
  Assumes inclusion by both ends and the query table module.
*/
`ifndef FCQ_PARAMS_SVH
`define FCQ_PARAMS_SVH

`define FCQ_ADDR_W          24
`define FCQ_DATA_W          16
`define FCQ_CMD_OFF_W       11
`define FCQ_OFF_UNLOCK1     11'h555
`define FCQ_OFF_UNLOCK2     11'h2aa
`define FCQ_OFF_ZERO        11'h000
`define FCQ_CMD_UNLOCK1     8'haa
`define FCQ_CMD_UNLOCK2     8'h55
`define FCQ_CMD_PROGRAM     8'ha0
`define FCQ_CMD_ERASE       8'h80
`define FCQ_CMD_SECT_ERASE  8'h30
`define FCQ_CMD_CHIP_ERASE  8'h10
`define FCQ_CMD_WBUF_LOAD   8'h25
`define FCQ_CMD_WBUF_COMMIT 8'h29
`define FCQ_CMD_QUERY       8'h98
`define FCQ_CMD_RESET       8'hf0
`define FCQ_CMD_LOCK_ENTRY  8'h40
`define FCQ_CMD_PWD_ENTRY   8'h60
`define FCQ_CMD_PPB_ENTRY   8'hc0
`define FCQ_CMD_EXIT1       8'h90
`define FCQ_CMD_EXIT2       8'h00
`define FCQ_WBUF_PAGE_LSB   5
`define FCQ_WBUF_MAX_WC     16'h001f
`define FCQ_LOCK_PERSIST_BIT 1
`define FCQ_LOCK_PWD_BIT    2
`define FCQ_INVALID_DATA    16'h0000

`define FCQ_OFF_SIG_Q       8'h10
`define FCQ_OFF_SIG_R       8'h11
`define FCQ_OFF_SIG_Y       8'h12
`define FCQ_OFF_PCMD_LO     8'h13
`define FCQ_OFF_PCMD_HI     8'h14
`define FCQ_OFF_PEXT_LO     8'h15
`define FCQ_OFF_PEXT_HI     8'h16
`define FCQ_OFF_ACMD_LO     8'h17
`define FCQ_OFF_ACMD_HI     8'h18
`define FCQ_OFF_AEXT_LO     8'h19
`define FCQ_OFF_AEXT_HI     8'h1a
`define FCQ_RST_SIG_Q       16'h0051
`define FCQ_RST_SIG_R       16'h0052
`define FCQ_RST_SIG_Y       16'h0059
`define FCQ_RST_PCMD_LO     16'h0002
`define FCQ_RST_PCMD_HI     16'h0000
`define FCQ_RST_PEXT_LO     16'h0040
`define FCQ_RST_PEXT_HI     16'h0000
`define FCQ_RST_ACMD_LO     16'h0000
`define FCQ_RST_ACMD_HI     16'h0000
`define FCQ_RST_AEXT_LO     16'h0000
`define FCQ_RST_AEXT_HI     16'h0000

`endif

// ==== inc/fcq_pkg.sv ====
/*
  Types shared by both ends of the flash command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcq_pkg;
  typedef enum logic [3:0] {
    FCQ_S_READ      = 4'h0,
    FCQ_S_UNL1      = 4'h1,
    FCQ_S_UNL2      = 4'h2,
    FCQ_S_PROG      = 4'h3,
    FCQ_S_ERASE     = 4'h4,
    FCQ_S_WB_WC     = 4'h5,
    FCQ_S_WB_LOAD   = 4'h6,
    FCQ_S_WB_COMMIT = 4'h7,
    FCQ_S_QUERY     = 4'h8,
    FCQ_S_MODE      = 4'h9,
    FCQ_S_MODE_PROG = 4'ha,
    FCQ_S_MODE_ERAS = 4'hb,
    FCQ_S_MODE_EXIT = 4'hc
  } fcq_state_t;

  typedef enum logic [1:0] {
    FCQ_M_LOCK = 2'h0,
    FCQ_M_PWD  = 2'h1,
    FCQ_M_PPB  = 2'h2
  } fcq_mode_t;

  typedef enum logic [3:0] {
    FCQ_OP_NONE         = 4'h0,
    FCQ_OP_PROGRAM      = 4'h1,
    FCQ_OP_SECT_ERASE   = 4'h2,
    FCQ_OP_CHIP_ERASE   = 4'h3,
    FCQ_OP_BUF_LOAD     = 4'h4,
    FCQ_OP_BUF_COMMIT   = 4'h5,
    FCQ_OP_LOCK_PROG    = 4'h6,
    FCQ_OP_LOCK_ABORT   = 4'h7,
    FCQ_OP_PWD_PROG     = 4'h8,
    FCQ_OP_PPB_PROG     = 4'h9,
    FCQ_OP_PPB_PREPROG  = 4'ha,
    FCQ_OP_PPB_ERASE    = 4'hb
  } fcq_op_t;

  typedef enum logic [1:0] {
    FCQ_RK_ARRAY   = 2'h0,
    FCQ_RK_QUERY   = 2'h1,
    FCQ_RK_STATUS  = 2'h2,
    FCQ_RK_INVALID = 2'h3
  } fcq_rd_kind_t;

  typedef enum logic [2:0] {
    FCQ_H_IDLE   = 3'h0,
    FCQ_H_ADDR   = 3'h1,
    FCQ_H_LATCH  = 3'h2,
    FCQ_H_STROBE = 3'h3,
    FCQ_H_WAIT   = 3'h4
  } fcq_hstate_t;
endpackage

// ==== inc/fcq_bus_if.sv ====
/*
  Flash bus between the host controller end and the device end.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

interface fcq_bus_if;
  logic [`FCQ_ADDR_W-1:0] addr;
  logic [`FCQ_DATA_W-1:0] wdata;
  logic                   address_valid_strobe_n;
  logic                   we;
  logic                   re;
  logic [`FCQ_DATA_W-1:0] rdata;
  logic                   rvalid;

  modport dev (
    input  addr, wdata, address_valid_strobe_n, we, re,
    output rdata, rvalid
  );
  modport host (
    output addr, wdata, address_valid_strobe_n, we, re,
    input  rdata, rvalid
  );
endinterface

// ==== hdl/fcq_cfi_rom.sv ====
/*
  Query identification table lookup, combinational.
  Assumes the caller registers the word it reads.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

module fcq_cfi_rom (
  input  wire logic [7:0]             i_offset,
  output logic      [`FCQ_DATA_W-1:0] o_word,
  output logic                        o_hit
);
  always_comb begin
    o_hit = 1'b1;
    unique case (i_offset)
      `FCQ_OFF_SIG_Q:   o_word = `FCQ_RST_SIG_Q;
      `FCQ_OFF_SIG_R:   o_word = `FCQ_RST_SIG_R;
      `FCQ_OFF_SIG_Y:   o_word = `FCQ_RST_SIG_Y;
      `FCQ_OFF_PCMD_LO: o_word = `FCQ_RST_PCMD_LO;
      `FCQ_OFF_PCMD_HI: o_word = `FCQ_RST_PCMD_HI;
      `FCQ_OFF_PEXT_LO: o_word = `FCQ_RST_PEXT_LO;
      `FCQ_OFF_PEXT_HI: o_word = `FCQ_RST_PEXT_HI;
      `FCQ_OFF_ACMD_LO: o_word = `FCQ_RST_ACMD_LO;
      `FCQ_OFF_ACMD_HI: o_word = `FCQ_RST_ACMD_HI;
      `FCQ_OFF_AEXT_LO: o_word = `FCQ_RST_AEXT_LO;
      `FCQ_OFF_AEXT_HI: o_word = `FCQ_RST_AEXT_HI;
      default: begin
        o_word = `FCQ_INVALID_DATA;
        o_hit  = 1'b0;
      end
    endcase
  end
endmodule

// ==== hdl/fcq_dev.sv ====
/*
  Device end: decodes flash bus cycles into array and protection operations
  and answers reads from the array, the query table or protection status.
  Assumes the array side answers i_array_rdata in the same cycle as o_rd_req.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

module fcq_dev #(
  parameter bit SMALL_DENSITY = 1'b0
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  fcq_bus_if.dev                      bus,
  output logic                        o_op_valid,
  output fcq_pkg::fcq_op_t            o_op_code,
  output logic      [`FCQ_ADDR_W-1:0] o_op_addr,
  output logic      [`FCQ_DATA_W-1:0] o_op_data,
  output logic      [9:0]             o_op_sector,
  output logic      [3:0]             o_op_bank,
  output logic                        o_rd_req,
  output logic      [`FCQ_ADDR_W-1:0] o_rd_addr,
  input  wire logic [`FCQ_DATA_W-1:0] i_array_rdata,
  input  wire logic                   i_sector_prot,
  output logic                        o_query_active
);
  import fcq_pkg::*;

  fcq_state_t             state_r;
  fcq_mode_t              mode_r;
  logic [3:0]             qbank_r;
  logic                   avd_q_r;
  logic                   held_r;
  logic [`FCQ_ADDR_W-1:0] lat_r;
  logic [`FCQ_ADDR_W-1:0] page_r;
  logic [15:0]            left_r;
  logic                   erase_pend_r;
  fcq_rd_kind_t           kind_r;
  logic [`FCQ_DATA_W-1:0] cfi_r;
  logic                   rd_pend_r;
  logic [`FCQ_DATA_W-1:0] rdata_r;
  logic                   rvalid_r;

  logic [`FCQ_ADDR_W-1:0] a;
  logic [7:0]             cmd;
  logic [`FCQ_CMD_OFF_W-1:0] off;
  logic                   wr;
  logic                   rd;
  logic [9:0]             sect;
  logic [3:0]             bank;
  logic [`FCQ_DATA_W-1:0] rom_word;
  logic                   rom_hit;
  fcq_rd_kind_t           kind;

  // Strobe rise latches; a clock-edge strobe with no prior rise uses the live bus
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      avd_q_r <= 1'b1;
      held_r  <= 1'b0;
      lat_r   <= '0;
    end else begin
      avd_q_r <= bus.address_valid_strobe_n;
      if (bus.we || bus.re) begin
        held_r <= 1'b0;
      end else if (bus.address_valid_strobe_n && !avd_q_r) begin
        held_r <= 1'b1;
        lat_r  <= bus.addr;
      end
    end
  end

  assign a    = held_r ? lat_r : bus.addr;
  assign cmd  = bus.wdata[7:0];
  assign off  = a[`FCQ_CMD_OFF_W-1:0];
  assign wr   = bus.we;
  assign rd   = bus.re && !bus.we;
  assign sect = SMALL_DENSITY ? {1'b0, a[22:14]} : a[23:14];
  assign bank = SMALL_DENSITY ? a[22:19] : a[23:20];

  fcq_cfi_rom fcq_cfi_rom_inst (
    .i_offset (a[7:0]),
    .o_word   (rom_word),
    .o_hit    (rom_hit)
  );

  // Command sequencer; an unexpected write drops back to array reads, except in query state (stays) and the mode erase and exit steps (back to mode)
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r      <= FCQ_S_READ;
      mode_r       <= FCQ_M_LOCK;
      qbank_r      <= '0;
      page_r       <= '0;
      left_r       <= '0;
      erase_pend_r <= 1'b0;
      o_op_valid   <= 1'b0;
      o_op_code    <= FCQ_OP_NONE;
      o_op_addr    <= '0;
      o_op_data    <= '0;
      o_op_sector  <= '0;
      o_op_bank    <= '0;
    end else begin
      o_op_valid <= 1'b0;
      if (erase_pend_r) begin
        erase_pend_r <= 1'b0;
        o_op_valid   <= 1'b1;
        o_op_code    <= FCQ_OP_PPB_ERASE;
      end else if (wr) begin
        o_op_addr   <= a;
        o_op_data   <= bus.wdata;
        o_op_sector <= sect;
        o_op_bank   <= bank;
        state_r     <= FCQ_S_READ;
        unique case (state_r)
          FCQ_S_READ: begin
            if (off == `FCQ_OFF_UNLOCK1 && cmd == `FCQ_CMD_UNLOCK1) begin
              state_r <= FCQ_S_UNL1;
            end else if (off == `FCQ_OFF_UNLOCK1 && cmd == `FCQ_CMD_PROGRAM) begin
              state_r <= FCQ_S_PROG;
            end else if (off == `FCQ_OFF_UNLOCK1 && cmd == `FCQ_CMD_ERASE) begin
              state_r <= FCQ_S_ERASE;
            end else if (cmd == `FCQ_CMD_WBUF_LOAD) begin
              state_r <= FCQ_S_WB_WC;
            end else if (off == `FCQ_OFF_UNLOCK1 && cmd == `FCQ_CMD_QUERY) begin
              state_r <= FCQ_S_QUERY;
              qbank_r <= bank;
            end
          end
          FCQ_S_UNL1: begin
            if (off == `FCQ_OFF_UNLOCK2 && cmd == `FCQ_CMD_UNLOCK2) begin
              state_r <= FCQ_S_UNL2;
            end
          end
          FCQ_S_UNL2: begin
            if (off == `FCQ_OFF_UNLOCK1) begin
              state_r <= FCQ_S_MODE;
              unique case (cmd)
                `FCQ_CMD_LOCK_ENTRY: mode_r <= FCQ_M_LOCK;
                `FCQ_CMD_PWD_ENTRY:  mode_r <= FCQ_M_PWD;
                `FCQ_CMD_PPB_ENTRY:  mode_r <= FCQ_M_PPB;
                default:             state_r <= FCQ_S_READ;
              endcase
            end
          end
          FCQ_S_PROG: begin
            o_op_valid <= 1'b1;
            o_op_code  <= FCQ_OP_PROGRAM;
          end
          FCQ_S_ERASE: begin
            if (cmd == `FCQ_CMD_SECT_ERASE) begin
              o_op_valid <= 1'b1;
              o_op_code  <= FCQ_OP_SECT_ERASE;
            end else if (off == `FCQ_OFF_UNLOCK1 && cmd == `FCQ_CMD_CHIP_ERASE) begin
              o_op_valid <= 1'b1;
              o_op_code  <= FCQ_OP_CHIP_ERASE;
            end
          end
          FCQ_S_WB_WC: begin
            // A count beyond one page cannot be honoured
            if (bus.wdata <= `FCQ_WBUF_MAX_WC) begin
              state_r <= FCQ_S_WB_LOAD;
              left_r  <= bus.wdata;
              page_r  <= '0;
            end
          end
          FCQ_S_WB_LOAD: begin
            if (page_r == '0 ||
                page_r[`FCQ_ADDR_W-1:`FCQ_WBUF_PAGE_LSB] ==
                a[`FCQ_ADDR_W-1:`FCQ_WBUF_PAGE_LSB]) begin
              o_op_valid <= 1'b1;
              o_op_code  <= FCQ_OP_BUF_LOAD;
              page_r     <= {a[`FCQ_ADDR_W-1:`FCQ_WBUF_PAGE_LSB],
                             `FCQ_WBUF_PAGE_LSB'(1)};
              left_r     <= left_r - 16'h0001;
              state_r    <= (left_r == '0) ? FCQ_S_WB_COMMIT : FCQ_S_WB_LOAD;
            end
          end
          FCQ_S_WB_COMMIT: begin
            if (cmd == `FCQ_CMD_WBUF_COMMIT) begin
              o_op_valid <= 1'b1;
              o_op_code  <= FCQ_OP_BUF_COMMIT;
            end
          end
          FCQ_S_QUERY: begin
            state_r <= FCQ_S_QUERY;
            if (bank == qbank_r && off == `FCQ_OFF_ZERO
                && cmd == `FCQ_CMD_RESET) begin
              state_r <= FCQ_S_READ;
            end
          end
          FCQ_S_MODE: begin
            if (cmd == `FCQ_CMD_PROGRAM) begin
              state_r <= FCQ_S_MODE_PROG;
            end else if (cmd == `FCQ_CMD_ERASE && mode_r == FCQ_M_PPB) begin
              state_r <= FCQ_S_MODE_ERAS;
            end else if (cmd == `FCQ_CMD_EXIT1) begin
              state_r <= FCQ_S_MODE_EXIT;
            end
          end
          FCQ_S_MODE_PROG: begin
            state_r    <= FCQ_S_MODE;
            o_op_valid <= 1'b1;
            unique case (mode_r)
              FCQ_M_LOCK: o_op_code <= (bus.wdata[`FCQ_LOCK_PERSIST_BIT]
                                        && bus.wdata[`FCQ_LOCK_PWD_BIT])
                                       ? FCQ_OP_LOCK_ABORT : FCQ_OP_LOCK_PROG;
              FCQ_M_PWD:  o_op_code <= FCQ_OP_PWD_PROG;
              FCQ_M_PPB:  o_op_code <= FCQ_OP_PPB_PROG;
              default:    o_op_valid <= 1'b0;
            endcase
          end
          FCQ_S_MODE_ERAS: begin
            state_r <= FCQ_S_MODE;
            if (cmd == `FCQ_CMD_SECT_ERASE) begin
              o_op_valid   <= 1'b1;
              o_op_code    <= FCQ_OP_PPB_PREPROG;
              erase_pend_r <= 1'b1;
            end
          end
          FCQ_S_MODE_EXIT: begin
            state_r <= (cmd == `FCQ_CMD_EXIT2) ? FCQ_S_READ : FCQ_S_MODE;
          end
          default: state_r <= FCQ_S_READ;
        endcase
      end
    end
  end

  always_comb begin
    kind = FCQ_RK_ARRAY;
    if (state_r == FCQ_S_QUERY && bank == qbank_r) begin
      kind = rom_hit ? FCQ_RK_QUERY : FCQ_RK_INVALID;
    end else if (state_r == FCQ_S_MODE && mode_r == FCQ_M_PPB) begin
      kind = FCQ_RK_STATUS;
    end
  end

  // Reads answer two cycles after the strobe, whatever their kind
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_req  <= 1'b0;
      o_rd_addr <= '0;
      kind_r    <= FCQ_RK_ARRAY;
      cfi_r     <= '0;
      rd_pend_r <= 1'b0;
      rdata_r   <= '0;
      rvalid_r  <= 1'b0;
    end else begin
      o_rd_req  <= rd && kind != FCQ_RK_QUERY && kind != FCQ_RK_INVALID;
      rd_pend_r <= rd;
      rvalid_r  <= rd_pend_r;
      if (rd) begin
        o_rd_addr <= a;
        kind_r    <= kind;
        cfi_r     <= rom_word;
      end
      if (rd_pend_r) begin
        unique case (kind_r)
          FCQ_RK_ARRAY:   rdata_r <= i_array_rdata;
          FCQ_RK_QUERY:   rdata_r <= cfi_r;
          FCQ_RK_STATUS:  rdata_r <= {15'h0000, ~i_sector_prot};
          FCQ_RK_INVALID: rdata_r <= `FCQ_INVALID_DATA;
          default:        rdata_r <= `FCQ_INVALID_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_query_active <= 1'b0;
    end else begin
      o_query_active <= (state_r == FCQ_S_QUERY);
    end
  end

  assign bus.rdata  = rdata_r;
  assign bus.rvalid = rvalid_r;
endmodule

// ==== hdl/fcq_host.sv ====
/*
  Host end: turns single read or write requests into flash bus cycles.
  Assumes the device answers a read within a few cycles on rvalid.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

module fcq_host (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  fcq_bus_if.host                     bus,
  input  wire logic                   i_cmd_valid,
  input  wire logic                   i_cmd_write,
  input  wire logic [`FCQ_ADDR_W-1:0] i_cmd_addr,
  input  wire logic [`FCQ_DATA_W-1:0] i_cmd_data,
  output logic                        o_cmd_ready,
  output logic      [`FCQ_DATA_W-1:0] o_rd_data,
  output logic                        o_rd_valid
);
  import fcq_pkg::*;

  fcq_hstate_t            state_r;
  logic                   write_r;
  logic [`FCQ_ADDR_W-1:0] addr_r;
  logic [`FCQ_DATA_W-1:0] wdata_r;
  logic                   avd_n_r;
  logic                   we_r;
  logic                   re_r;

  // One bus cycle per request, so each password part is its own sequence
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= FCQ_H_IDLE;
      write_r     <= 1'b0;
      addr_r      <= '0;
      wdata_r     <= '0;
      avd_n_r     <= 1'b1;
      we_r        <= 1'b0;
      re_r        <= 1'b0;
      o_cmd_ready <= 1'b1;
      o_rd_data   <= '0;
      o_rd_valid  <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      we_r       <= 1'b0;
      re_r       <= 1'b0;
      unique case (state_r)
        FCQ_H_IDLE: begin
          if (i_cmd_valid) begin
            o_cmd_ready <= 1'b0;
            write_r     <= i_cmd_write;
            addr_r      <= i_cmd_addr;
            wdata_r     <= i_cmd_data;
            avd_n_r     <= 1'b0;
            state_r     <= FCQ_H_ADDR;
          end
        end
        FCQ_H_ADDR: begin
          avd_n_r <= 1'b1;
          state_r <= FCQ_H_LATCH;
        end
        FCQ_H_LATCH: begin
          we_r    <= write_r;
          re_r    <= !write_r;
          state_r <= FCQ_H_STROBE;
        end
        FCQ_H_STROBE: begin
          if (write_r) begin
            o_cmd_ready <= 1'b1;
            state_r     <= FCQ_H_IDLE;
          end else begin
            state_r <= FCQ_H_WAIT;
          end
        end
        FCQ_H_WAIT: begin
          if (bus.rvalid) begin
            o_rd_data   <= bus.rdata;
            o_rd_valid  <= 1'b1;
            o_cmd_ready <= 1'b1;
            state_r     <= FCQ_H_IDLE;
          end
        end
        default: state_r <= FCQ_H_IDLE;
      endcase
    end
  end

  assign bus.addr                   = addr_r;
  assign bus.wdata                  = wdata_r;
  assign bus.address_valid_strobe_n = avd_n_r;
  assign bus.we                     = we_r;
  assign bus.re                     = re_r;
endmodule

// ==== tb/fcq_props.sv ====
/*
  Bus-level checks on the link between host end and device end.
  Assumes one clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

module fcq_props (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst,
  input wire logic [`FCQ_ADDR_W-1:0] addr,
  input wire logic [`FCQ_DATA_W-1:0] wdata,
  input wire logic                   address_valid_strobe_n,
  input wire logic                   we,
  input wire logic                   re,
  input wire logic [`FCQ_DATA_W-1:0] rdata,
  input wire logic                   rvalid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_rd_answer; re |-> !rvalid ##1 !rvalid ##1 rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered after two cycles");
  property p_rv_cause; rvalid |-> $past(re, 2); endproperty
  a_rv_cause: assert property (p_rv_cause)
    else $error("read answer without a read cycle");
  property p_wr_strobe; we |-> !$past(address_valid_strobe_n, 2) && $past(address_valid_strobe_n);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("write cycle without address strobe");
  property p_avd_lead; $fell(address_valid_strobe_n) |-> ##2 (we || re); endproperty
  a_avd_lead: assert property (p_avd_lead)
    else $error("address strobe not followed by a cycle");
  property p_addr_hold; (we || re) |-> $stable({addr, wdata}); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved between strobe and cycle");
  property p_one_kind; !(we && re); endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("read and write in one cycle");
  property p_cycle_pulse; (we || re) |=> !(we || re) [*2]; endproperty
  a_cycle_pulse: assert property (p_cycle_pulse)
    else $error("bus cycle strobe longer than one cycle");
  property p_avd_pulse; !address_valid_strobe_n |=> address_valid_strobe_n; endproperty
  a_avd_pulse: assert property (p_avd_pulse)
    else $error("address strobe longer than one cycle");

  c_read: cover property (re ##2 rvalid);
  c_write: cover property (we);
  c_query: cover property (re && addr[7:0] == 8'h10);
endmodule

// ==== tb/fcq_test.sv ====
/*
  Self-checking bench: host end drives device end over the shared bus.
  Assumes the array answers combinationally from the read address.
*/
`timescale 1ns/1ns
`include "fcq_params.svh"

module fcq_test;
  import fcq_pkg::*;
  logic        clk, rst, cmd_valid, cmd_write, cmd_ready, rd_valid, op_valid, rd_req, prot;
  logic        qact;
  logic [39:0] f;
  logic [39:0] exp_ad [$];
  logic [23:0] cmd_addr, op_addr, rd_addr, bank, pa;
  logic [15:0] cmd_data, rd_data, op_data, arr_data, e;
  logic [15:0] qry [11];
  logic [9:0]  op_sector;
  logic [3:0]  op_bank;
  logic [31:0] seed, r;
  fcq_op_t     op_code;
  fcq_op_t     exp_op [$];
  logic [15:0] exp_rd [$];
  int          errors, comparisons, cycles;

  fcq_bus_if bus_if ();
  fcq_dev fcq_dev_inst (.i_sys_clk(clk), .i_rst(rst), .bus(bus_if), .o_op_valid(op_valid),
    .o_op_code(op_code), .o_op_addr(op_addr), .o_op_data(op_data), .o_op_sector(op_sector),
    .o_op_bank(op_bank), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_array_rdata(arr_data),
    .i_sector_prot(prot), .o_query_active(qact));
  fcq_host fcq_host_inst (.i_sys_clk(clk), .i_rst(rst), .bus(bus_if), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
    .o_cmd_ready(cmd_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
  fcq_props fcq_props_inst (.i_sys_clk(clk), .i_rst(rst), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .address_valid_strobe_n(bus_if.address_valid_strobe_n),
    .we(bus_if.we), .re(bus_if.re), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));

  // Array answers only while a read is requested, so a missing request shows
  assign arr_data = rd_req ? (rd_addr[15:0] ^ 16'h5a5a) : 16'h0bad;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Command code with a random upper byte, which the device must ignore
  function logic [15:0] cw(input logic [7:0] c);
    logic [31:0] x;
    x = rnd();
    return {x[15:8], c};
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task cmd(input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #10;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk);
    #10;
    cmd_valid = 1'b0;
  endtask

  task rd(input logic [23:0] a, input logic [15:0] x);
    exp_rd.push_back(x);
    cmd(1'b0, a, 16'h0000);
  endtask

  task unlock(input logic [7:0] c);
    cmd(1'b1, 24'h000555, cw(8'haa));
    cmd(1'b1, 24'h0002aa, cw(8'h55));
    cmd(1'b1, 24'h000555, cw(c));
  endtask

  task opw(input fcq_op_t c, input logic [23:0] a, input logic [15:0] d);
    exp_op.push_back(c);
    cmd(1'b1, a, d);
    exp_ad.push_back({a, d});
  endtask

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      e = (exp_rd.size() > 0) ? exp_rd.pop_front() : ~rd_data;
      check(rd_data, e);
    end
    if (op_valid === 1'b1) begin
      e = (exp_op.size() > 0) ? {12'h000, exp_op.pop_front()} : ~{12'h000, op_code};
      check({12'h000, op_code}, e);
      f = (exp_ad.size() > 0) ? exp_ad.pop_front() : ~{op_addr, op_data};
      check(op_data, f[15:0]);
      check(op_addr[15:0], f[31:16]);
      check({6'h00, op_sector}, {6'h00, f[39:30]});
      check({12'h000, op_bank}, {12'h000, f[39:36]});
    end
  end

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    qry = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000};
    seed = 32'hd0d9f63c;
    rst = 1'b1;
    {cmd_valid, cmd_write, prot} = 3'h0;
    cmd_addr = 24'h000000;
    cmd_data = 16'h0000;
    repeat (20) @(posedge clk);
    #10;
    rst = 1'b0;
    r = rnd();
    bank = {r[3:0], 20'h00000};
    cmd(1'b1, bank | 24'h000555, cw(8'h98));
    cmd(1'b1, bank ^ 24'h100000, cw(8'hf0));
    for (int i = 0; i < 11; i++)
      rd(bank | (24'h000010 + 24'(i)), qry[i]);
    rd(bank | 24'h000005, 16'h0000);
    rd(bank ^ 24'h100010, 16'h5a4a);
    check({15'h0000, qact}, 16'h0001);
    cmd(1'b1, bank, cw(8'hf0));
    rd(bank | 24'h000010, (bank[15:0] | 16'h0010) ^ 16'h5a5a);
    check({15'h0000, qact}, 16'h0000);
    r = rnd();
    pa = {r[23:5], 5'h00};
    cmd(1'b1, 24'h000555, cw(8'ha0));
    opw(FCQ_OP_PROGRAM, pa, r[31:16]);
    cmd(1'b1, 24'h000555, cw(8'h80));
    opw(FCQ_OP_SECT_ERASE, pa, cw(8'h30));
    cmd(1'b1, 24'h000555, cw(8'h80));
    opw(FCQ_OP_CHIP_ERASE, 24'h000555, cw(8'h10));
    cmd(1'b1, 24'h000555, cw(8'h80));
    cmd(1'b1, 24'h000555, cw(8'h77));
    cmd(1'b1, 24'h000555, cw(8'ha0));
    opw(FCQ_OP_PROGRAM, pa | 24'h00001f, r[15:0]);
    cmd(1'b1, pa, cw(8'h25));
    cmd(1'b1, pa, 16'h0001);
    opw(FCQ_OP_BUF_LOAD, pa | 24'h000003, r[31:16]);
    opw(FCQ_OP_BUF_LOAD, pa | 24'h00001f, r[15:0]);
    opw(FCQ_OP_BUF_COMMIT, pa, cw(8'h29));
    cmd(1'b1, pa, cw(8'h25));
    cmd(1'b1, pa, 16'h0001);
    opw(FCQ_OP_BUF_LOAD, pa | 24'h000007, r[31:16]);
    cmd(1'b1, pa ^ 24'h000020, r[15:0]);
    cmd(1'b1, pa, cw(8'h29));
    cmd(1'b1, 24'h000000, cw(8'h80));
    cmd(1'b1, 24'h000000, cw(8'h30));
    prot = r[7];
    unlock(8'hc0);
    rd(pa, {15'h0000, ~r[7]});
    cmd(1'b1, 24'h000000, cw(8'h80));
    opw(FCQ_OP_PPB_PREPROG, 24'h000000, cw(8'h30));
    exp_op.push_back(FCQ_OP_PPB_ERASE);
    exp_ad.push_back({cmd_addr, cmd_data});
    cmd(1'b1, 24'h000000, cw(8'h90));
    cmd(1'b1, 24'h000000, cw(8'h00));
    unlock(8'h60);
    cmd(1'b1, 24'h000000, cw(8'ha0));
    opw(FCQ_OP_PWD_PROG, 24'h000002, r[15:0]);
    rd(24'h000003, 16'h5a59);
    cmd(1'b1, 24'h000000, cw(8'h90));
    cmd(1'b1, 24'h000000, cw(8'h00));
    unlock(8'h40);
    cmd(1'b1, 24'h000000, cw(8'ha0));
    opw(FCQ_OP_LOCK_ABORT, 24'h000000, 16'h0006);
    cmd(1'b1, 24'h000000, cw(8'h90));
    cmd(1'b1, 24'h000000, cw(8'h00));
    rd(pa, pa[15:0] ^ 16'h5a5a);
    repeat (10) @(posedge clk);
    check(16'(exp_rd.size() + exp_op.size()), 16'h0000);
    test_done();
  end
endmodule
